/* shared/tcts_consts.svh */
// constants for the timer cross-trigger selection block
// assumes inclusion by bare name from package and rtl files
`ifndef TCTS_CONSTS_SVH
`define TCTS_CONSTS_SVH

`define TCTS_SEL_W          5
`define TCTS_NUM_TIMERS     7
`define TCTS_PD1_SRCS       6
`define TCTS_PD0_SRCS       2
`define TCTS_CODE_SUB0      5'h10
`define TCTS_CODE_SUB1      5'h11
`define TCTS_SEL_RESET      5'h00

// timer indices
`define TCTS_IDX_ADV_A      0
`define TCTS_IDX_ADV_B      1
`define TCTS_IDX_GEN_SIX    2
`define TCTS_IDX_GEN_SEVEN  3
`define TCTS_IDX_GEN_TWELVE 4
`define TCTS_IDX_GEN_EIGHT  5
`define TCTS_IDX_GEN_ZERO   6

// capability widths and compare channel counts
`define TCTS_CNT_W16        6'h10
`define TCTS_CNT_W32        6'h20
`define TCTS_PRESCALE_W     4'h8
`define TCTS_REPEAT_W       4'h8
`define TCTS_CC_ADV_A       3'h4
`define TCTS_CC_OTHER       3'h2

`endif

/* shared/tcts_pkg.sv */
// types for the timer cross-trigger selection block
// assumes tcts_consts.svh is on the include path
`include "tcts_consts.svh"
package tcts_pkg;
    typedef logic [`TCTS_SEL_W-1:0]      tcts_sel_t;
    typedef logic [`TCTS_NUM_TIMERS-1:0] tcts_vec_t;
    typedef enum logic {
        TCTS_PD_ZERO,
        TCTS_PD_ONE
    } tcts_domain_t;
    typedef enum logic [1:0] {
        TCTS_SRC_PEER,
        TCTS_SRC_SUB0,
        TCTS_SRC_SUB1,
        TCTS_SRC_NONE
    } tcts_src_t;
endpackage : tcts_pkg

/* rtl/tcts_mux.sv */
// one timer's trigger source decoder and registered trigger
// assumes peer triggers and subscriber ports are synchronous to clk_sys
`timescale 1ns/1ps
`include "tcts_consts.svh"
module tcts_mux (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    // selection
    input  wire tcts_pkg::tcts_sel_t    sel,
    input  wire tcts_pkg::tcts_domain_t domain,
    // sources
    input  wire logic [`TCTS_PD1_SRCS-1:0] pd1_trig,
    input  wire logic [`TCTS_PD0_SRCS-1:0] pd0_trig,
    input  wire logic              sub0,
    input  wire logic              sub1,
    // result
    output logic                   ext_trig,
    output logic                   sel_reserved
);
    import tcts_pkg::*;

    tcts_src_t src;
    logic      peer_bit;
    logic      next_ext_trig;
    logic      next_sel_reserved;

    always_comb begin
        src      = TCTS_SRC_NONE;
        peer_bit = 1'b0;
        if (sel == `TCTS_CODE_SUB0) begin
            src = TCTS_SRC_SUB0;
        end else if (sel == `TCTS_CODE_SUB1) begin
            src = TCTS_SRC_SUB1;
        end else if (domain == TCTS_PD_ONE &&
                     sel < 5'(`TCTS_PD1_SRCS)) begin
            src      = TCTS_SRC_PEER;
            peer_bit = pd1_trig[sel[2:0]];
        end else if (domain == TCTS_PD_ZERO &&
                     sel < 5'(`TCTS_PD0_SRCS)) begin
            src      = TCTS_SRC_PEER;
            peer_bit = pd0_trig[sel[0]];
        end
        case (src)
            TCTS_SRC_PEER: next_ext_trig = peer_bit;
            TCTS_SRC_SUB0: next_ext_trig = sub0;
            TCTS_SRC_SUB1: next_ext_trig = sub1;
            TCTS_SRC_NONE: next_ext_trig = 1'b0;
            default:       next_ext_trig = 1'b0;
        endcase
        next_sel_reserved = (src == TCTS_SRC_NONE);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ext_trig     <= 1'b0;
            sel_reserved <= 1'b0;
        end else if (clk_en) begin
            ext_trig     <= next_ext_trig;
            sel_reserved <= next_sel_reserved;
        end
    end
endmodule : tcts_mux

/* rtl/tcts_top.sv */
// cross-trigger selection for seven timers in two power domains,
// plus the fixed capability set of each timer instance
// assumes all trigger inputs are synchronous to clk_sys
//
// Overview of operation
// - domain one codes 0-5 pick peer triggers
// - domain zero codes 0-1 pick peer triggers
// - code 16 routes subscriber port zero
// - code 17 routes subscriber port one
// - per-instance widths, channels and features fixed
`timescale 1ns/1ps
`include "tcts_consts.svh"
module tcts_top (
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    // per-timer select, index order a,b,six,seven,twelve,eight,zero
    input  wire tcts_pkg::tcts_sel_t  sel_adv_a,
    input  wire tcts_pkg::tcts_sel_t  sel_adv_b,
    input  wire tcts_pkg::tcts_sel_t  sel_gen_six,
    input  wire tcts_pkg::tcts_sel_t  sel_gen_seven,
    input  wire tcts_pkg::tcts_sel_t  sel_gen_twelve,
    input  wire tcts_pkg::tcts_sel_t  sel_gen_eight,
    input  wire tcts_pkg::tcts_sel_t  sel_gen_zero,
    // trigger output zero of each timer
    input  wire tcts_pkg::tcts_vec_t  trigger_output_zero,
    // event subscriber ports, domain one then domain zero
    input  wire logic                 sub0_pd1,
    input  wire logic                 sub1_pd1,
    input  wire logic                 sub0_pd0,
    input  wire logic                 sub1_pd0,
    // external trigger to each timer, and reserved-code flags
    output tcts_pkg::tcts_vec_t       ext_trig,
    output tcts_pkg::tcts_vec_t       sel_reserved,
    // capability set, one bit per timer for flags, a packed field per timer for channel count and widths
    output tcts_pkg::tcts_vec_t       cap_wide_counter,
    output tcts_pkg::tcts_vec_t       cap_prescaler,
    output tcts_pkg::tcts_vec_t       cap_repeat,
    output tcts_pkg::tcts_vec_t       cap_phase_load,
    output tcts_pkg::tcts_vec_t       cap_deadband,
    output tcts_pkg::tcts_vec_t       cap_fault,
    output logic [3*`TCTS_NUM_TIMERS-1:0] cap_cc_channels,
    output logic [6*`TCTS_NUM_TIMERS-1:0] cap_counter_width,
    output logic [4*`TCTS_NUM_TIMERS-1:0] cap_prescale_width,
    output logic [4*`TCTS_NUM_TIMERS-1:0] cap_repeat_width
);
    import tcts_pkg::*;

    tcts_sel_t sel_arr [`TCTS_NUM_TIMERS];
    logic [`TCTS_PD1_SRCS-1:0] pd1_trig;
    logic [`TCTS_PD0_SRCS-1:0] pd0_trig;

    assign sel_arr[`TCTS_IDX_ADV_A]      = sel_adv_a;
    assign sel_arr[`TCTS_IDX_ADV_B]      = sel_adv_b;
    assign sel_arr[`TCTS_IDX_GEN_SIX]    = sel_gen_six;
    assign sel_arr[`TCTS_IDX_GEN_SEVEN]  = sel_gen_seven;
    assign sel_arr[`TCTS_IDX_GEN_TWELVE] = sel_gen_twelve;
    assign sel_arr[`TCTS_IDX_GEN_EIGHT]  = sel_gen_eight;
    assign sel_arr[`TCTS_IDX_GEN_ZERO]   = sel_gen_zero;

    // domain one code order: a, b, six, seven, twelve, eight
    assign pd1_trig[0] = trigger_output_zero[`TCTS_IDX_ADV_A];
    assign pd1_trig[1] = trigger_output_zero[`TCTS_IDX_ADV_B];
    assign pd1_trig[2] = trigger_output_zero[`TCTS_IDX_GEN_SIX];
    assign pd1_trig[3] = trigger_output_zero[`TCTS_IDX_GEN_SEVEN];
    assign pd1_trig[4] = trigger_output_zero[`TCTS_IDX_GEN_TWELVE];
    assign pd1_trig[5] = trigger_output_zero[`TCTS_IDX_GEN_EIGHT];
    // domain zero code order: zero, eight
    assign pd0_trig[0] = trigger_output_zero[`TCTS_IDX_GEN_ZERO];
    assign pd0_trig[1] = trigger_output_zero[`TCTS_IDX_GEN_EIGHT];

    genvar gi;
    generate
        for (gi = 0; gi < `TCTS_NUM_TIMERS; gi++) begin : g_timer
            localparam bit IS_PD0 = (gi == `TCTS_IDX_GEN_ZERO) ||
                                    (gi == `TCTS_IDX_GEN_EIGHT);
            logic next_wide;
            logic next_pre;
            logic next_adv;
            logic [2:0] next_cc;
            logic [5:0] next_cw;
            logic [3:0] next_pw;
            logic [3:0] next_rw;

            tcts_mux u_mux (
                .clk_sys      (clk_sys),
                .rst_n        (rst_n),
                .clk_en       (clk_en),
                .sel          (sel_arr[gi]),
                .domain       (IS_PD0 ? TCTS_PD_ZERO : TCTS_PD_ONE),
                .pd1_trig     (pd1_trig),
                .pd0_trig     (pd0_trig),
                .sub0         (IS_PD0 ? sub0_pd0 : sub0_pd1),
                .sub1         (IS_PD0 ? sub1_pd0 : sub1_pd1),
                .ext_trig     (ext_trig[gi]),
                .sel_reserved (sel_reserved[gi])
            );

            // feature flags, fixed per instance by the generate index
            always_comb begin
                case (gi)
                    `TCTS_IDX_ADV_A: begin
                        next_wide = 1'b0;
                        next_pre  = 1'b1;
                        next_adv  = 1'b1;
                    end
                    `TCTS_IDX_ADV_B: begin
                        next_wide = 1'b0;
                        next_pre  = 1'b1;
                        next_adv  = 1'b1;
                    end
                    `TCTS_IDX_GEN_SIX: begin
                        next_wide = 1'b0;
                        next_pre  = 1'b1;
                        next_adv  = 1'b0;
                    end
                    `TCTS_IDX_GEN_SEVEN: begin
                        next_wide = 1'b0;
                        next_pre  = 1'b1;
                        next_adv  = 1'b0;
                    end
                    `TCTS_IDX_GEN_TWELVE: begin
                        next_wide = 1'b1;
                        next_pre  = 1'b0;
                        next_adv  = 1'b0;
                    end
                    `TCTS_IDX_GEN_EIGHT: begin
                        next_wide = 1'b0;
                        next_pre  = 1'b1;
                        next_adv  = 1'b0;
                    end
                    `TCTS_IDX_GEN_ZERO: begin
                        next_wide = 1'b0;
                        next_pre  = 1'b1;
                        next_adv  = 1'b0;
                    end
                    default: begin
                        next_wide = 1'b0;
                        next_pre  = 1'b0;
                        next_adv  = 1'b0;
                    end
                endcase
            end

            // channel count and field widths per instance
            always_comb begin
                case (gi)
                    `TCTS_IDX_ADV_A: begin
                        next_cc = `TCTS_CC_ADV_A;
                        next_cw = `TCTS_CNT_W16;
                        next_pw = `TCTS_PRESCALE_W;
                        next_rw = `TCTS_REPEAT_W;
                    end
                    `TCTS_IDX_ADV_B: begin
                        next_cc = `TCTS_CC_OTHER;
                        next_cw = `TCTS_CNT_W16;
                        next_pw = `TCTS_PRESCALE_W;
                        next_rw = `TCTS_REPEAT_W;
                    end
                    `TCTS_IDX_GEN_SIX: begin
                        next_cc = `TCTS_CC_OTHER;
                        next_cw = `TCTS_CNT_W16;
                        next_pw = `TCTS_PRESCALE_W;
                        next_rw = 4'h0;
                    end
                    `TCTS_IDX_GEN_SEVEN: begin
                        next_cc = `TCTS_CC_OTHER;
                        next_cw = `TCTS_CNT_W16;
                        next_pw = `TCTS_PRESCALE_W;
                        next_rw = 4'h0;
                    end
                    `TCTS_IDX_GEN_TWELVE: begin
                        next_cc = `TCTS_CC_OTHER;
                        next_cw = `TCTS_CNT_W32;
                        next_pw = 4'h0;
                        next_rw = 4'h0;
                    end
                    `TCTS_IDX_GEN_EIGHT: begin
                        next_cc = `TCTS_CC_OTHER;
                        next_cw = `TCTS_CNT_W16;
                        next_pw = `TCTS_PRESCALE_W;
                        next_rw = 4'h0;
                    end
                    `TCTS_IDX_GEN_ZERO: begin
                        next_cc = `TCTS_CC_OTHER;
                        next_cw = `TCTS_CNT_W16;
                        next_pw = `TCTS_PRESCALE_W;
                        next_rw = 4'h0;
                    end
                    default: begin
                        next_cc = 3'h0;
                        next_cw = 6'h00;
                        next_pw = 4'h0;
                        next_rw = 4'h0;
                    end
                endcase
            end

            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    cap_wide_counter[gi]      <= 1'b0;
                    cap_prescaler[gi]         <= 1'b0;
                    cap_repeat[gi]            <= 1'b0;
                    cap_phase_load[gi]        <= 1'b0;
                    cap_deadband[gi]          <= 1'b0;
                    cap_fault[gi]             <= 1'b0;
                    cap_cc_channels[3*gi+:3]  <= 3'h0;
                    cap_counter_width[6*gi+:6] <= 6'h00;
                    cap_prescale_width[4*gi+:4] <= 4'h0;
                    cap_repeat_width[4*gi+:4] <= 4'h0;
                end else if (clk_en) begin
                    cap_wide_counter[gi]      <= next_wide;
                    cap_prescaler[gi]         <= next_pre;
                    cap_repeat[gi]            <= next_adv;
                    cap_phase_load[gi]        <= next_adv;
                    cap_deadband[gi]          <= next_adv;
                    cap_fault[gi]             <= next_adv;
                    cap_cc_channels[3*gi+:3]  <= next_cc;
                    cap_counter_width[6*gi+:6] <= next_cw;
                    cap_prescale_width[4*gi+:4] <= next_pw;
                    cap_repeat_width[4*gi+:4] <= next_rw;
                end
            end
        end
    endgenerate
endmodule : tcts_top

/* tb/tcts_top_sva.sv */
// checker for trigger selection at the top ports
// assumes binding onto tcts_top
`timescale 1ns/1ps
`include "tcts_consts.svh"
module tcts_top_sva
    import tcts_pkg::*;
(
    // clock
    input wire logic      clk_sys,
    input wire logic      rst_n,
    input wire logic      clk_en,
    // selects
    input wire tcts_sel_t sel_adv_b,
    input wire tcts_sel_t sel_gen_six,
    input wire tcts_sel_t sel_gen_twelve,
    input wire tcts_sel_t sel_gen_eight,
    input wire tcts_sel_t sel_gen_zero,
    // sources
    input wire tcts_vec_t trigger_output_zero,
    input wire logic      sub0_pd1,
    input wire logic      sub1_pd0,
    // results
    input wire tcts_vec_t ext_trig,
    input wire tcts_vec_t sel_reserved,
    input wire tcts_vec_t cap_wide_counter,
    input wire logic [3*`TCTS_NUM_TIMERS-1:0] cap_cc_channels
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    pd1_peer_a: assert property (clk_en && sel_gen_six < 5'h06
        |=> ext_trig[2] == $past(trigger_output_zero[sel_gen_six]))
        else $error("domain one peer trigger not routed");
    pd0_self_a: assert property (clk_en && sel_gen_zero == 5'h00
        |=> ext_trig[6] == $past(trigger_output_zero[6]))
        else $error("domain zero code zero not routed");
    pd0_cross_a: assert property (clk_en && sel_gen_eight == 5'h01
        |=> ext_trig[5] == $past(trigger_output_zero[5]))
        else $error("domain zero code one not routed");
    sub_zero_a: assert property (clk_en && sel_adv_b == 5'h10
        |=> ext_trig[1] == $past(sub0_pd1))
        else $error("subscriber port zero not routed");
    sub_one_a: assert property (clk_en && sel_gen_eight == 5'h11
        |=> ext_trig[5] == $past(sub1_pd0))
        else $error("subscriber port one not routed");
    reserved_a: assert property (clk_en && sel_gen_twelve inside
        {[5'h06:5'h0F], [5'h12:5'h1F]} |=> !ext_trig[4] && sel_reserved[4])
        else $error("reserved code gave a trigger");
    caps_set_a: assert property (clk_en |=> cap_wide_counter == 7'h10
        && cap_cc_channels[2:0] == 3'h4)
        else $error("capability set wrong");
    freeze_a: assert property (!clk_en |=> $stable(ext_trig))
        else $error("outputs moved while disabled");
    cover property (clk_en && sel_adv_b == 5'h10);
    cover property (clk_en && sel_gen_twelve == 5'h12);
    cover property (!clk_en);
endmodule : tcts_top_sva

bind tcts_top tcts_top_sva tcts_top_sva_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .clk_en(clk_en), .sel_adv_b(sel_adv_b),
    .sel_gen_six(sel_gen_six), .sel_gen_twelve(sel_gen_twelve),
    .sel_gen_eight(sel_gen_eight), .sel_gen_zero(sel_gen_zero),
    .trigger_output_zero(trigger_output_zero), .sub0_pd1(sub0_pd1),
    .sub1_pd0(sub1_pd0), .ext_trig(ext_trig), .sel_reserved(sel_reserved),
    .cap_wide_counter(cap_wide_counter), .cap_cc_channels(cap_cc_channels));

/* tb/tcts_peer_model.sv */
// peer timers and event fabric giving trigger levels
// assumes the bench seeds the generator first
`timescale 1ns/1ps
module tcts_peer_model
    import tcts_pkg::*;
(
    // clock
    input  wire logic clk_sys,
    // levels
    output tcts_vec_t  trig,
    output logic [3:0] sub
);
    // fresh levels each cycle, away from the sampling edge
    always @(negedge clk_sys) begin
        trig <= 7'($urandom);
        sub  <= 4'($urandom);
    end
endmodule : tcts_peer_model

/* tb/timer_cross_trigger_select_tb.sv */
// self-checking bench for the trigger selection block
// assumes tcts_top, its checker and the peer model
`timescale 1ns/1ps
module timer_cross_trigger_select_tb;
    import tcts_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    tcts_sel_t sel [7] = '{default: 5'h00};
    tcts_vec_t trig, ext_trig, res, cw, cp, cr, cl, cd, cf;
    logic [3:0] sub;
    logic [20:0] ccc;
    logic [41:0] ccw;
    logic [27:0] cpw, crw;
    logic [14:0] notes [$];
    logic [14:0] last = '0;
    int bad_count = 0;
    int n_compared = 0;
    wire logic [160:0] caps = {cw, cp, cr, cl, cd, cf, ccc, ccw, cpw, crw};
    localparam logic [160:0] caps_exp = {7'h10, 7'h6F, {4{7'h03}},
        {6{3'h2}}, 3'h4, {2{6'h10}}, 6'h20, {4{6'h10}},
        {2{4'h8}}, 4'h0, {4{4'h8}}, {5{4'h0}}, {2{4'h8}}};
    always #12.5 clk_sys = ~clk_sys;
    tcts_peer_model tcts_peer_model_i (.clk_sys(clk_sys), .trig(trig),
        .sub(sub));
    tcts_top tcts_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
        .sel_adv_a(sel[0]), .sel_adv_b(sel[1]), .sel_gen_six(sel[2]),
        .sel_gen_seven(sel[3]), .sel_gen_twelve(sel[4]),
        .sel_gen_eight(sel[5]), .sel_gen_zero(sel[6]),
        .trigger_output_zero(trig), .sub0_pd1(sub[0]), .sub1_pd1(sub[1]),
        .sub0_pd0(sub[2]), .sub1_pd0(sub[3]), .ext_trig(ext_trig),
        .sel_reserved(res), .cap_wide_counter(cw), .cap_prescaler(cp),
        .cap_repeat(cr), .cap_phase_load(cl), .cap_deadband(cd),
        .cap_fault(cf), .cap_cc_channels(ccc), .cap_counter_width(ccw),
        .cap_prescale_width(cpw), .cap_repeat_width(crw));
    // returns {reserved, trigger}; timers 5 and 6 sit in domain zero
    function automatic logic [1:0] pick(int i, tcts_sel_t s);
        logic pd0;
        pd0 = (i > 4);
        if (s == 5'h10) return {1'b0, pd0 ? sub[2] : sub[0]};
        if (s == 5'h11) return {1'b0, pd0 ? sub[3] : sub[1]};
        if (!pd0 && s < 5'h06) return {1'b0, trig[s]};
        if (pd0 && s < 5'h02) return {1'b0, trig[6 - s]};
        return 2'b10;
    endfunction : pick
    task automatic check(logic [160:0] seen, logic [160:0] want);
        n_compared++;
        if (seen !== want) begin
            bad_count++;
            $display("ERROR %0t seen %0h want %0h", $time, seen, want);
        end
    endtask : check
    task automatic end_of_test;
        if (notes.size() != 0) bad_count++;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    // drive one cycle at the falling edge and note what must follow
    task automatic step(logic r, logic e, int c);
        logic [1:0] p;
        int v;
        @(negedge clk_sys);
        rst_n = r;
        clk_en = e;
        for (int i = 0; i < 7; i++) begin
            v = $urandom_range(0, 7);
            v = ($urandom_range(0, 3) == 0) ? $urandom_range(0, 31)
                : (v < 6) ? v : v + 10;
            sel[i] = 5'((c >= 0) ? c : v);
        end
        #1;
        if (!r) begin
            last = '0;
        end else if (e) begin
            last[14] = 1'b1;
            for (int i = 0; i < 7; i++) begin
                p = pick(i, sel[i]);
                last[i] = p[0];
                last[7 + i] = p[1];
            end
        end
        notes.push_back(last);
    endtask : step
    initial begin : watch
        logic [14:0] n;
        forever begin
            @(posedge clk_sys);
            #1;
            if (notes.size() > 0) begin
                n = notes.pop_front();
                check(161'(ext_trig), 161'(n[6:0]));
                check(161'(res), 161'(n[13:7]));
                check(caps, n[14] ? caps_exp : '0);
            end
        end
    end
    initial begin
        void'($urandom(32'h0469));
        repeat (5) step(1'b0, 1'b1, 0);
        for (int c = 0; c < 32; c++) step(1'b1, 1'b1, c);
        repeat (400) step(1'b1, $urandom_range(0, 7) != 0, -1);
        step(1'b0, 1'b0, -1);
        repeat (60) step(1'b1, $urandom_range(0, 5) != 0, -1);
        repeat (2) @(posedge clk_sys);
        end_of_test();
    end
endmodule : timer_cross_trigger_select_tb
